// file: include/dav_pkg.sv
// Shared definitions for the display audio verb responder: verb codes,
// parameter ids, fixed capability words, node map and state layouts.
// Assumes verbs are already deserialised from the codec link.
package dav_pkg;

  // ----------------------------------------------------------------
  // Verb codes (12-bit ids, and 4-bit ids carrying a 16-bit payload)
  // ----------------------------------------------------------------
  localparam logic [11:0] VERB_PARAM_RD  = 12'hF00;
  localparam logic [11:0] VERB_SEL_WR    = 12'h701;
  localparam logic [11:0] VERB_SEL_RD    = 12'hF01;
  localparam logic [11:0] VERB_ENTRY_RD  = 12'hF02;
  localparam logic [11:0] VERB_PWR_WR    = 12'h705;
  localparam logic [11:0] VERB_PWR_RD    = 12'hF05;
  localparam logic [11:0] VERB_STRM_WR   = 12'h706;
  localparam logic [11:0] VERB_STRM_RD   = 12'hF06;
  localparam logic [11:0] VERB_PINCTL_WR = 12'h707;
  localparam logic [11:0] VERB_PINCTL_RD = 12'hF07;
  localparam logic [11:0] VERB_UNSOL_WR  = 12'h708;
  localparam logic [11:0] VERB_UNSOL_RD  = 12'hF08;
  localparam logic [11:0] VERB_DIG_RD    = 12'hF0D;
  localparam logic [11:0] VERB_DIG1_WR   = 12'h70D;
  localparam logic [11:0] VERB_DIG2_WR   = 12'h70E;
  localparam logic [11:0] VERB_DIG3_WR   = 12'h73E;
  localparam logic [11:0] VERB_DIG4_WR   = 12'h73F;
  localparam logic [11:0] VERB_CNT_WR    = 12'h72D;
  localparam logic [11:0] VERB_CNT_RD    = 12'hF2D;
  localparam logic [3:0]  VERB_MUTE_WR   = 4'h3;
  localparam logic [3:0]  VERB_MUTE_RD   = 4'hB;

  // ----------------------------------------------------------------
  // Parameter ids and fixed answers
  // ----------------------------------------------------------------
  localparam logic [7:0]  PARAM_WIDGET_CAPS = 8'h09;
  localparam logic [7:0]  PARAM_PIN_CAPS    = 8'h0C;
  localparam logic [7:0]  PARAM_CONN_LEN    = 8'h0E;
  localparam logic [7:0]  PARAM_PWR_STATES  = 8'h0F;
  localparam logic [7:0]  PARAM_OUT_AMP     = 8'h12;
  localparam logic [7:0]  PARAM_DEV_LEN     = 8'h15;
  localparam logic [31:0] PWR_STATES_VAL    = 32'h80000009;
  localparam logic [31:0] PIN_WIDGET_VAL    = 32'h0040678D;
  localparam logic [31:0] PIN_CAPS_BASIC    = 32'h09000094;
  localparam int          MULTISTREAM_BIT   = 25;
  localparam logic [31:0] CONN_LEN_VAL      = 32'h00000003;
  localparam logic [31:0] OUT_AMP_VAL       = 32'h80000000;
  localparam logic [31:0] DEV_LEN_VAL       = 32'h00000000;
  localparam logic [7:0]  CONN_ENTRY_BASE   = 8'h02;
  localparam int          MUTE_BIT          = 7;

  // ----------------------------------------------------------------
  // Node map and power codes
  // ----------------------------------------------------------------
  localparam int         NODE_COUNT     = 3;
  localparam logic [7:0] CONV_FIRST     = 8'h02;
  localparam logic [7:0] CONV_LAST      = 8'h04;
  localparam logic [7:0] PIN_FIRST      = 8'h05;
  localparam logic [7:0] PIN_LAST       = 8'h07;
  localparam logic [1:0] PWR_D0         = 2'h0;
  localparam logic [1:0] PWR_D3         = 2'h3;

  typedef enum logic [4:0] {
    OP_NONE       = 5'h00, OP_PARAM_GET  = 5'h01, OP_PWR_SET    = 5'h02,
    OP_PWR_GET    = 5'h03, OP_STRM_SET   = 5'h04, OP_STRM_GET   = 5'h05,
    OP_DIG_GET    = 5'h06, OP_DIG1_SET   = 5'h07, OP_DIG2_SET   = 5'h08,
    OP_DIG3_SET   = 5'h09, OP_DIG4_SET   = 5'h0A, OP_CNT_SET    = 5'h0B,
    OP_CNT_GET    = 5'h0C, OP_MUTE_SET   = 5'h0D, OP_MUTE_GET   = 5'h0E,
    OP_SEL_SET    = 5'h0F, OP_SEL_GET    = 5'h10, OP_ENTRY_GET  = 5'h11,
    OP_PINCTL_SET = 5'h12, OP_PINCTL_GET = 5'h13, OP_UNSOL_SET  = 5'h14,
    OP_UNSOL_GET  = 5'h15
  } dav_op_t;

  // ----------------------------------------------------------------
  // Carriers and state layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic [7:0]  node;
    logic [19:0] cmd;
  } dav_verb_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
  } dav_resp_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] node;
    logic [5:0] tag;
  } dav_unsol_t;

  typedef struct packed {
    logic [20:0] rsvd_hi;
    logic        settings_reset_flag;
    logic        clock_stop_permitted;
    logic        error_flag;
    logic [1:0]  rsvd_mid;
    logic [1:0]  actual_state_field;
    logic [1:0]  rsvd_lo;
    logic [1:0]  echoed_request_field;
  } dav_pwr_report_t;

  typedef struct packed {
    logic generation_level;
    logic professional_use;
    logic non_pcm;
    logic copyright;
    logic pre_emphasis;
    logic validity_config;
    logic validity;
    logic digital_enable;
  } dav_dig1_t;

  typedef struct packed {
    logic [7:0] rsvd_hi;
    logic       keep_alive;
    logic [2:0] rsvd_mid;
    logic [3:0] coding_type;
    logic       rsvd_lo;
    logic [6:0] category_code;
    dav_dig1_t  byte1;
  } dav_dig_report_t;

  typedef struct packed {
    logic [1:0] pwr_req;
    logic [1:0] pwr_actual;
    logic [3:0] link_stream_number;
    logic [3:0] lowest_channel;
    dav_dig1_t  dig1;
    logic [6:0] category_code;
    logic       keep_alive;
    logic [3:0] coding_type;
    logic [3:0] chan_count;
  } dav_conv_cfg_t;

  typedef struct packed {
    logic [1:0] pwr_req;
    logic [1:0] pwr_actual;
    logic       mute;
    logic       output_enable;
    logic [1:0] packet_type_code;
    logic       unsolicited_enable;
    logic [5:0] unsol_tag;
    logic [7:0] conn_select;
  } dav_pin_cfg_t;

  localparam dav_conv_cfg_t CONV_RST = '{pwr_req: PWR_D3, pwr_actual: PWR_D3,
    link_stream_number: 4'h0, lowest_channel: 4'h0, dig1: 8'h01,
    category_code: 7'h00, keep_alive: 1'b1, coding_type: 4'h0, chan_count: 4'h0};
  localparam dav_pin_cfg_t PIN_RST = '{pwr_req: PWR_D3, pwr_actual: PWR_D3,
    mute: 1'b1, output_enable: 1'b1, packet_type_code: 2'h0,
    unsolicited_enable: 1'b0, unsol_tag: 6'h00, conn_select: 8'h00};

endpackage

// file: core/dav_conv_node.sv
// One output converter node: holds stream, digital converter and
// channel count settings. Assumes op is OP_NONE unless this node is addressed.
`timescale 1ns/10ps
module dav_conv_node
  import dav_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire dav_op_t op,
  input  wire logic [7:0] payload,
  output dav_conv_cfg_t   cfg
);
  dav_conv_cfg_t next_cfg;

  always_comb begin
    next_cfg = cfg;
    next_cfg.pwr_actual = cfg.pwr_req;
    case (op)
      OP_PWR_SET:  next_cfg.pwr_req = payload[1:0];
      OP_STRM_SET: begin
        next_cfg.link_stream_number = payload[7:4];
        next_cfg.lowest_channel     = payload[3:0];
      end
      OP_DIG1_SET: next_cfg.dig1 = payload;
      OP_DIG2_SET: next_cfg.category_code = payload[6:0];
      OP_DIG3_SET: begin
        next_cfg.keep_alive  = payload[7];
        next_cfg.coding_type = payload[3:0];
      end
      OP_CNT_SET:  next_cfg.chan_count = payload[3:0];
      default: ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= CONV_RST;
    end else begin
      cfg <= next_cfg;
    end
  end
endmodule // dav_conv_node

// file: core/dav_pin_node.sv
// One pin complex node: holds mute, pin control, connection select and
// unsolicited enable. Assumes op is OP_NONE unless this node is addressed.
`timescale 1ns/10ps
module dav_pin_node
  import dav_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire dav_op_t     op,
  input  wire logic [15:0] payload,
  output dav_pin_cfg_t     cfg
);
  dav_pin_cfg_t next_cfg;

  always_comb begin
    next_cfg = cfg;
    next_cfg.pwr_actual = cfg.pwr_req;
    case (op)
      OP_PWR_SET: next_cfg.pwr_req = payload[1:0];
      OP_MUTE_SET: begin
        // Only the output amp exists; input-amp requests are dropped
        if (payload[15]) begin
          next_cfg.mute = payload[MUTE_BIT];
        end
      end
      OP_SEL_SET: next_cfg.conn_select = payload[7:0];
      OP_PINCTL_SET: begin
        next_cfg.output_enable    = payload[6];
        next_cfg.packet_type_code = payload[1:0];
      end
      OP_UNSOL_SET: begin
        next_cfg.unsolicited_enable = payload[7];
        next_cfg.unsol_tag          = payload[5:0];
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg <= PIN_RST;
    end else begin
      cfg <= next_cfg;
    end
  end
endmodule // dav_pin_node

// file: core/dav_verb_responder.sv
// Verb responder for the display audio codec: decodes set and get verbs
// for three converter nodes and three pin nodes and answers each one.
// Assumes verbs arrive deserialised, one per valid strobe, synchronous to clk.
`timescale 1ns/10ps
// Operation
// - Supported states: extended bit, D3, D0
// - Power report echoes last requested state
// - Power report shows actual state, reset D3
// - Settings reset flag always reads zero
// - Power error flag always reads zero
// - Clock stop permitted flag reads zero
// - Stream and lowest channel stored, readable
// - Digital report packs keep-alive, type, category
// - First digital byte fields; enable resets one
// - Validity bit drives every sub-frame flag
// - Second digital byte holds seven-bit category
// - Third byte: keep-alive, coding type; fourth ignored
// - Channel count minus one, stored, readable
// - Mute payload: selects, index, mute bit
// - Mute report: bit seven only, resets one
// - Pin widget capabilities word is fixed
// - Pin capabilities; multistream zero in basic mode
// - Connection list length: short form, three
// - Entry per pin: 05h-02h, 06h-03h, 07h-04h
// - Pin control: output enable, packet type
// - Unsolicited responses only while enabled
module dav_verb_responder
  import dav_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire dav_verb_t             verb,
  input  wire logic                  mst_mode,
  input  wire logic [NODE_COUNT-1:0] pin_event,
  output dav_resp_t                  resp,
  output dav_unsol_t                 unsol,
  output logic [NODE_COUNT-1:0]      subframe_validity,
  output dav_conv_cfg_t              conv_cfg [NODE_COUNT],
  output dav_pin_cfg_t               pin_cfg [NODE_COUNT]
);

  // ----------------------------------------------------------------
  // Verb decode
  // ----------------------------------------------------------------
  dav_op_t       raw_op;
  dav_op_t       op;
  logic          conv_hit;
  logic          pin_hit;
  logic [1:0]    conv_idx;
  logic [1:0]    pin_idx;
  dav_op_t       conv_op [NODE_COUNT];
  dav_op_t       pin_op [NODE_COUNT];

  always_comb begin
    conv_hit = verb.valid && (verb.node >= CONV_FIRST) && (verb.node <= CONV_LAST);
    pin_hit  = verb.valid && (verb.node >= PIN_FIRST) && (verb.node <= PIN_LAST);
    conv_idx = verb.node[1:0] - CONV_FIRST[1:0];
    pin_idx  = verb.node[1:0] - PIN_FIRST[1:0];
    raw_op   = OP_NONE;
    if (verb.cmd[19:16] == VERB_MUTE_WR) begin
      raw_op = OP_MUTE_SET;
    end else if (verb.cmd[19:16] == VERB_MUTE_RD) begin
      raw_op = OP_MUTE_GET;
    end else begin
      case (verb.cmd[19:8])
        VERB_PARAM_RD:  raw_op = OP_PARAM_GET;
        VERB_PWR_WR:    raw_op = OP_PWR_SET;
        VERB_PWR_RD:    raw_op = OP_PWR_GET;
        VERB_STRM_WR:   raw_op = OP_STRM_SET;
        VERB_STRM_RD:   raw_op = OP_STRM_GET;
        VERB_DIG_RD:    raw_op = OP_DIG_GET;
        VERB_DIG1_WR:   raw_op = OP_DIG1_SET;
        VERB_DIG2_WR:   raw_op = OP_DIG2_SET;
        VERB_DIG3_WR:   raw_op = OP_DIG3_SET;
        VERB_DIG4_WR:   raw_op = OP_DIG4_SET;
        VERB_CNT_WR:    raw_op = OP_CNT_SET;
        VERB_CNT_RD:    raw_op = OP_CNT_GET;
        VERB_SEL_WR:    raw_op = OP_SEL_SET;
        VERB_SEL_RD:    raw_op = OP_SEL_GET;
        VERB_ENTRY_RD:  raw_op = OP_ENTRY_GET;
        VERB_PINCTL_WR: raw_op = OP_PINCTL_SET;
        VERB_PINCTL_RD: raw_op = OP_PINCTL_GET;
        VERB_UNSOL_WR:  raw_op = OP_UNSOL_SET;
        VERB_UNSOL_RD:  raw_op = OP_UNSOL_GET;
        default:        raw_op = OP_NONE;
      endcase
    end
    // A verb meant for the other node class is dropped as unknown
    case (raw_op)
      OP_PARAM_GET, OP_PWR_SET, OP_PWR_GET: begin
        op = (conv_hit || pin_hit) ? raw_op : OP_NONE;
      end
      OP_STRM_SET, OP_STRM_GET, OP_DIG_GET, OP_DIG1_SET, OP_DIG2_SET,
      OP_DIG3_SET, OP_DIG4_SET, OP_CNT_SET, OP_CNT_GET: begin
        op = conv_hit ? raw_op : OP_NONE;
      end
      OP_MUTE_SET, OP_MUTE_GET, OP_SEL_SET, OP_SEL_GET, OP_ENTRY_GET,
      OP_PINCTL_SET, OP_PINCTL_GET, OP_UNSOL_SET, OP_UNSOL_GET: begin
        op = pin_hit ? raw_op : OP_NONE;
      end
      default: op = OP_NONE;
    endcase
  end

  // ----------------------------------------------------------------
  // Node state
  // ----------------------------------------------------------------
  for (genvar k = 0; k < NODE_COUNT; k++) begin : g_node
    assign conv_op[k] = (conv_hit && conv_idx == 2'(k)) ? op : OP_NONE;
    assign pin_op[k]  = (pin_hit && pin_idx == 2'(k)) ? op : OP_NONE;

    dav_conv_node u_conv (
      .clk     (clk),
      .rst     (rst),
      .op      (conv_op[k]),
      .payload (verb.cmd[7:0]),
      .cfg     (conv_cfg[k])
    );

    dav_pin_node u_pin (
      .clk     (clk),
      .rst     (rst),
      .op      (pin_op[k]),
      .payload (verb.cmd[15:0]),
      .cfg     (pin_cfg[k])
    );
  end

  // ----------------------------------------------------------------
  // Response
  // ----------------------------------------------------------------
  dav_conv_cfg_t   cur_conv;
  dav_pin_cfg_t    cur_pin;
  dav_pwr_report_t pwr_rep;
  dav_dig_report_t dig_rep;
  logic [31:0]     rsp_data;
  dav_resp_t       next_resp;
  dav_op_t         resp_op;
  dav_op_t         next_resp_op;

  always_comb begin
    cur_conv = (conv_idx < 2'(NODE_COUNT)) ? conv_cfg[conv_idx] : CONV_RST;
    cur_pin  = (pin_idx < 2'(NODE_COUNT)) ? pin_cfg[pin_idx] : PIN_RST;
    pwr_rep  = '0;
    pwr_rep.echoed_request_field = conv_hit ? cur_conv.pwr_req : cur_pin.pwr_req;
    pwr_rep.actual_state_field = conv_hit ? cur_conv.pwr_actual : cur_pin.pwr_actual;
    dig_rep = '0;
    dig_rep.keep_alive    = cur_conv.keep_alive;
    dig_rep.coding_type   = cur_conv.coding_type;
    dig_rep.category_code = cur_conv.category_code;
    dig_rep.byte1         = cur_conv.dig1;
    rsp_data = '0;
    case (op)
      OP_PARAM_GET: begin
        case (verb.cmd[7:0])
          PARAM_PWR_STATES:  rsp_data = PWR_STATES_VAL;
          PARAM_WIDGET_CAPS: rsp_data = pin_hit ? PIN_WIDGET_VAL : '0;
          PARAM_PIN_CAPS: begin
            if (pin_hit) begin
              rsp_data = PIN_CAPS_BASIC;
              rsp_data[MULTISTREAM_BIT] = mst_mode;
            end
          end
          PARAM_CONN_LEN:    rsp_data = pin_hit ? CONN_LEN_VAL : '0;
          PARAM_OUT_AMP:     rsp_data = pin_hit ? OUT_AMP_VAL : '0;
          PARAM_DEV_LEN:     rsp_data = pin_hit ? DEV_LEN_VAL : '0;
          default:           rsp_data = '0;
        endcase
      end
      OP_PWR_GET:    rsp_data = pwr_rep;
      OP_STRM_GET:   rsp_data = {24'h000000, cur_conv.link_stream_number,
                                 cur_conv.lowest_channel};
      OP_DIG_GET:    rsp_data = dig_rep;
      OP_CNT_GET:    rsp_data = {28'h0000000, cur_conv.chan_count};
      OP_MUTE_GET: begin
        // Input amp is absent, so only an output-amp read sees the mute
        rsp_data[MUTE_BIT] = verb.cmd[15] & cur_pin.mute;
      end
      OP_SEL_GET:    rsp_data = {24'h000000, cur_pin.conn_select};
      OP_ENTRY_GET:  rsp_data = {24'h000000, CONN_ENTRY_BASE + {6'h00, pin_idx}};
      OP_PINCTL_GET: rsp_data = {25'h0000000, cur_pin.output_enable, 4'h0,
                                 cur_pin.packet_type_code};
      OP_UNSOL_GET:  rsp_data = {24'h000000, cur_pin.unsolicited_enable, 1'b0,
                                 cur_pin.unsol_tag};
      default:       rsp_data = '0;
    endcase
    next_resp.valid = verb.valid;
    next_resp.data  = rsp_data;
    next_resp_op    = op;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      resp    <= '0;
      resp_op <= OP_NONE;
    end else begin
      resp    <= next_resp;
      resp_op <= next_resp_op;
    end
  end

  // ----------------------------------------------------------------
  // Sub-frame validity and unsolicited responses
  // ----------------------------------------------------------------
  logic [NODE_COUNT-1:0] pending;
  logic [NODE_COUNT-1:0] next_pending;
  logic [NODE_COUNT-1:0] enabled;
  logic [NODE_COUNT-1:0] sent;
  logic [NODE_COUNT-1:0] next_validity;
  dav_unsol_t            next_unsol;

  always_comb begin
    for (int i = 0; i < NODE_COUNT; i++) begin
      enabled[i]       = pin_cfg[i].unsolicited_enable;
      next_validity[i] = conv_cfg[i].dig1.validity;
    end
    sent       = '0;
    next_unsol = '0;
    for (int i = NODE_COUNT - 1; i >= 0; i--) begin
      if (pending[i] && enabled[i]) begin
        sent                = '0;
        sent[i]             = 1'b1;
        next_unsol.valid    = 1'b1;
        next_unsol.node     = PIN_FIRST + 8'(i);
        next_unsol.tag      = pin_cfg[i].unsol_tag;
      end
    end
    // A new event wins over the clear of the one being sent; disabling drops it
    next_pending = ((pending & ~sent) | pin_event) & enabled;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending           <= '0;
      unsol             <= '0;
      subframe_validity <= '0;
    end else begin
      pending           <= next_pending;
      unsol             <= next_unsol;
      subframe_validity <= next_validity;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  resp_timing_a:
  assert property (verb.valid |=> resp.valid ##1 !resp.valid || $past(verb.valid))
    else $error("verb not answered exactly one cycle later");
  states_word_a:
  assert property (op == OP_PARAM_GET && verb.cmd[7:0] == PARAM_PWR_STATES
                   |=> resp.data == 32'h80000009)
    else $error("supported power states word wrong");
  pwr_flags_a:
  assert property (resp.valid && resp_op == OP_PWR_GET |-> resp.data[31:6] == '0
                   && resp.data[3:2] == 2'h0)
    else $error("power report flag or reserved bit set");
  pwr_echo_a:
  assert property (op == OP_PWR_SET && conv_hit ##1 verb.valid && op == OP_PWR_GET
                   && $stable(verb.node) |=> resp.data[1:0] == $past(verb.cmd[1:0], 2))
    else $error("power report does not echo request");
  pwr_settle_a:
  assert property (op == OP_PWR_SET && pin_hit ##1 op == OP_PWR_GET && $stable(verb.node)
                   ##1 op == OP_PWR_GET && $stable(verb.node)
                   |=> resp.data[5:4] == $past(resp.data[1:0]))
    else $error("actual state does not follow request");
  stream_back_a:
  assert property (op == OP_STRM_SET ##1 op == OP_STRM_GET && $stable(verb.node)
                   |=> resp.data == {24'h000000, $past(verb.cmd[7:0], 2)})
    else $error("stream and channel not read back");
  count_back_a:
  assert property (op == OP_CNT_SET ##1 op == OP_CNT_GET && $stable(verb.node)
                   |=> resp.data == {28'h0000000, $past(verb.cmd[3:0], 2)})
    else $error("channel count not read back");
  mute_report_a:
  assert property (resp.valid && resp_op == OP_MUTE_GET |-> resp.data[31:8] == '0
                   && resp.data[6:0] == 7'h00)
    else $error("mute report reserved bit set");
  entry_map_a:
  assert property (op == OP_ENTRY_GET |=> resp.data == 32'($past(verb.node)) - 32'd3)
    else $error("connection entry does not match pin");
  unsol_gate_a:
  assert property (unsol.valid
                   |-> |($past(enabled) & (3'b001 << (unsol.node[1:0] - PIN_FIRST[1:0]))))
    else $error("unsolicited response while disabled");
  validity_path_a:
  assert property (op == OP_DIG1_SET && conv_idx == 2'h0
                   |=> ##1 subframe_validity[0] == $past(verb.cmd[1], 2))
    else $error("validity flag not carried to sub-frames");

endmodule // dav_verb_responder

// file: tb/dav_host.sv
// Host controller model: turns bench requests into one-cycle verbs.
// Assumes requests come from the bench by non-blocking assignment.
`timescale 1ns/10ps
module dav_host
  import dav_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        req,
  input  wire logic [7:0]  req_node,
  input  wire logic [19:0] req_cmd,
  output dav_verb_t        verb
);
  dav_verb_t next_verb;

  always_comb begin
    next_verb = '{valid: req, node: req_node, cmd: req_cmd};
    // Only the two legal power codes are ever requested
    if (req_cmd[19:8] == VERB_PWR_WR) next_verb.cmd[1:0] = {2{req_cmd[0]}};
    // Idle fields toggle so a stale verb can never look valid
    if (!req) next_verb = '{valid: 1'b0, node: ~verb.node, cmd: ~verb.cmd};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      verb <= '0;
    end else begin
      verb <= next_verb;
    end
  end
endmodule // dav_host

// file: tb/tb.sv
// Testbench: random verbs and pin events checked against a queue-free model.
// Assumes dav_host delays each verb by one cycle.
`timescale 1ns/10ps
module tb
  import dav_pkg::*;
;
  logic          clk       = 1'b0;
  logic          rst       = 1'b1;
  logic          rq        = 1'b0;
  logic [7:0]    rq_n      = 8'h00;
  logic [19:0]   rq_c      = 20'h00000;
  logic          mst       = 1'b0;
  logic [2:0]    pin_event = 3'h0;
  dav_verb_t     verb;
  dav_resp_t     resp;
  dav_unsol_t    unsol;
  logic [2:0]    subframe_validity;
  dav_conv_cfg_t conv_cfg [NODE_COUNT];
  dav_pin_cfg_t  pin_cfg [NODE_COUNT];
  logic [19:0]   c;
  logic [31:0]   r;
  int            errors, checked, i;
  int            pw[9], sm[9], d1[9], cc[9], kt[9], cn[9], mu[9], se[9], pc[9], ue[9];
  logic [19:0]   ops [21] = '{20'hF0500, 20'hF0600, 20'hF0D00, 20'hF2D00, 20'hF0100,
    20'hF0200, 20'hF0700, 20'hF0800, 20'hB8000, 20'hF000F, 20'h70500, 20'h70600, 20'h70D00,
    20'h70E00, 20'h73E00, 20'h73F00, 20'h72D00, 20'h70100, 20'h70700, 20'h70800, 20'h38000};
  logic [7:0]    prm [7] = '{8'h09, 8'h0C, 8'h0E, 8'h0F, 8'h12, 8'h15, 8'h00};

  always #2.5 clk = ~clk;

  dav_host u_dav_host (.clk(clk), .rst(rst), .req(rq), .req_node(rq_n), .req_cmd(rq_c),
    .verb(verb));
  dav_verb_responder u_dav_verb_responder (.clk(clk), .rst(rst), .verb(verb),
    .mst_mode(mst), .pin_event(pin_event), .resp(resp), .unsol(unsol),
    .subframe_validity(subframe_validity), .conv_cfg(conv_cfg), .pin_cfg(pin_cfg));

  task automatic end_sim();
    if (errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Model: updates state on sets, returns the expected answer
  // ----------------------------------------------------------------
  task automatic model(input int n, input logic [19:0] v, output logic [31:0] e);
    bit cv;
    bit pn;
    logic [7:0] p;
    p = v[7:0];
    cv = n >= 2 && n <= 4;
    pn = n >= 5 && n <= 7;
    e = '0;
    if (pn && v[19:16] == 4'h3) begin
      if (v[15]) mu[n] = v[7];
    end else if (pn && v[19:16] == 4'hB) begin
      if (v[15]) e = mu[n] << 7;
    end else if (cv || pn) begin
      case (v[19:8])
        12'hF00: begin
          if (p == 8'h0F) e = 32'h80000009;
          if (pn && p == 8'h09) e = 32'h0040678D;
          if (pn && p == 8'h0C) e = 32'h09000094 | (32'(mst) << 25);
          if (pn && p == 8'h0E) e = 32'h00000003;
          if (pn && p == 8'h12) e = 32'h80000000;
        end
        12'h705: pw[n] = {2{p[0]}};
        12'hF05: e = pw[n] * 32'h11;
        12'h706: if (cv) sm[n] = p;
        12'hF06: if (cv) e = sm[n];
        12'h70D: if (cv) d1[n] = p;
        12'h70E: if (cv) cc[n] = p[6:0];
        12'h73E: if (cv) kt[n] = p & 8'h8F;
        12'hF0D: if (cv) e = {kt[n][7], 3'h0, kt[n][3:0], 1'b0, cc[n][6:0], d1[n][7:0]};
        12'h72D: if (cv) cn[n] = p[3:0];
        12'hF2D: if (cv) e = cn[n];
        12'h701: if (pn) se[n] = p;
        12'hF01: if (pn) e = se[n];
        12'hF02: if (pn) e = n - 3;
        12'h707: if (pn) pc[n] = p & 8'h43;
        12'hF07: if (pn) e = pc[n];
        12'h708: if (pn) ue[n] = p & 8'hBF;
        12'hF08: if (pn) e = ue[n];
        default: ;
      endcase
    end
  endtask

  task automatic xfer(input int n, input logic [19:0] v);
    logic [31:0] e;
    int k;
    model(n, v, e);
    @(posedge clk);
    rq <= 1'b1;
    rq_n <= 8'(n);
    rq_c <= v;
    @(posedge clk);
    rq <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (resp.valid !== 1'b1 && k < 4);
    cmp(32'(resp.valid), 1);
    cmp(resp.data, e);
    @(posedge clk);
    #1;
    cmp(32'(subframe_validity), {d1[4][1], d1[3][1], d1[2][1]});
  endtask

  // Back-to-back verbs; m hides fields still settling in the second answer
  task automatic burst(input int n, input logic [19:0] a, b, d, input logic [31:0] m);
    logic [31:0] e0, e1, e2;
    model(n, a, e0);
    model(n, b, e1);
    model(n, d, e2);
    @(posedge clk);
    rq <= 1'b1;
    rq_n <= 8'(n);
    rq_c <= a;
    @(posedge clk);
    rq_c <= b;
    @(posedge clk);
    rq_c <= d;
    #1;
    cmp(resp.data, e0);
    @(posedge clk);
    rq <= 1'b0;
    #1;
    cmp(resp.data & m, e1 & m);
    @(posedge clk);
    #1;
    cmp(resp.data, e2);
  endtask

  task automatic event_chk(input int p);
    @(posedge clk);
    pin_event <= 3'b001 << p;
    @(posedge clk);
    pin_event <= 3'h0;
    #1;
    cmp(32'(unsol.valid), 0);
    @(posedge clk);
    #1;
    cmp(32'(unsol.valid), ue[p + 5] >> 7);
    if (ue[p + 5] > 127) cmp({unsol.node, unsol.tag}, {8'(p + 5), ue[p + 5][5:0]});
  endtask

  initial begin
    #200000;
    errors++;
    end_sim();
  end

  initial begin
    void'($urandom(32'h5f873e7a));
    foreach (pw[n]) begin
      pw[n] = 3;
      d1[n] = 1;
      kt[n] = 8'h80;
      mu[n] = 1;
      pc[n] = 8'h40;
    end
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    for (int n = 0; n < 9; n++)
      for (i = 0; i < 10; i++) xfer(n, ops[i]);
    for (int n = 2; n < 8; n++) begin
      burst(n, 20'h70500 | 20'(n & 1), 20'hF0500, 20'hF0500, 32'hFFFFFFCF);
      burst(n, {12'h706, 8'(n * 19)}, 20'hF0600, {12'h72D, 8'(n)}, 32'hFFFFFFFF);
      burst(n, {12'h72D, 8'(n + 3)}, 20'hF2D00, 20'hF0D00, 32'hFFFFFFFF);
    end
    repeat (400) begin
      r = $urandom;
      c = ops[r % 21];
      r = $urandom;
      if (c[19:16] == 4'h3 || c[19:16] == 4'hB) c[15:0] = r[15:0];
      else if (c[19:8] == 12'hF00) c[7:0] = prm[r % 7];
      else c[7:0] = r[7:0];
      @(posedge clk);
      mst <= r[31];
      @(posedge clk);
      xfer(r[27:24] % 9, c);
      event_chk(r[23:20] % 3);
    end
    end_sim();
  end
endmodule // tb
